// >>> ptpc_regs.sv
// timing-message configuration bank with an axi4-lite slave and a frame classifier
// assumes frame descriptors arrive synchronous to clk, one frm_start pulse per frame
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module ptpc_regs
   import ptpc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic frm_start,
   input wire logic [1:0] frm_encap,
   input wire logic [3:0] frm_msg_type,
   input wire logic frm_mcast,
   input wire logic frm_reserved_addr,
   input wire logic [15:0] frm_udp_port,
   input wire logic frm_same_domain,
   input wire logic frm_from_master,
   input wire logic frm_on_host,
   input wire logic frm_assoc_ok,
   output logic cls_valid,
   output logic cls_is_ptp,
   output logic cls_use_lookup,
   output logic cls_to_host,
   output logic cls_to_others,
   output logic cls_top_queue,
   output logic cls_hdr_edit,
   output logic ptp_clk_en,
   output logic tail_tag_ts,
   output logic mode_bridge,
   output logic tc_p2p,
   output logic oc_master,
   output logic one_step
);

   function automatic logic [15:0] merge_word(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb,
                                              input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge_word = (old & ~lanes) | (data[15:0] & lanes);
   endfunction

   logic [15:0] cfg_a;
   logic [15:0] cfg_b;
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // write channel: address and data taken independently, response after both
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire do_wr = aw_got & w_got & ~s_axi_bvalid;
   wire next_aw_got = do_wr ? 1'b0 : (aw_got | aw_hs);
   wire next_w_got = do_wr ? 1'b0 : (w_got | w_hs);
   wire next_bvalid = do_wr | (s_axi_bvalid & ~s_axi_bready);
   wire wr_a = do_wr & (aw_addr[ADDR_W-1:2] == CFG_A_ADDR[ADDR_W-1:2]);
   wire wr_b = do_wr & (aw_addr[ADDR_W-1:2] == CFG_B_ADDR[ADDR_W-1:2]);
   wire [15:0] next_cfg_a = wr_a ? merge_word(cfg_a, w_data, w_strb, CFG_A_WMASK) : cfg_a;
   wire [15:0] next_cfg_b = wr_b ? merge_word(cfg_b, w_data, w_strb, CFG_B_WMASK) : cfg_b;

   // read channel: one word per request, answered the cycle after it is taken
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
   wire rd_a = s_axi_araddr[ADDR_W-1:2] == CFG_A_ADDR[ADDR_W-1:2];
   wire rd_b = s_axi_araddr[ADDR_W-1:2] == CFG_B_ADDR[ADDR_W-1:2];
   wire [31:0] rd_word = rd_a ? {16'h0000, cfg_a} : (rd_b ? {16'h0000, cfg_b} : 32'h0000_0000);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         if (aw_hs) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         s_axi_awready <= ~next_aw_got & ~next_bvalid;
         s_axi_wready <= ~next_w_got & ~next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (do_wr) begin
            s_axi_bresp <= (wr_a | wr_b) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_hs) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_a | rd_b) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // reserved bits are kept at zero by the write masks
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_a <= CFG_A_RST; // [RQ7] [RQ8] [RQ9] [RQ10] [RQ11]
         cfg_b <= CFG_B_RST; // [RQ12] [RQ17]
      end else begin
         cfg_a <= next_cfg_a;
         cfg_b <= next_cfg_b;
      end
   end

   // mode outputs follow the stored fields one cycle later
   wire ptp_on = cfg_a[A_PTP_EN];
   wire bridge_on = cfg_a[A_TAB] & ptp_on; // [RQ1]

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ptp_clk_en <= 1'b0;
         tail_tag_ts <= 1'b0;
         mode_bridge <= 1'b0;
         tc_p2p <= 1'b0;
         oc_master <= 1'b0;
         one_step <= 1'b1;
      end else begin
         ptp_clk_en <= ptp_on; // [RQ5]
         tail_tag_ts <= ptp_on; // [RQ6]
         mode_bridge <= bridge_on; // [RQ1]
         tc_p2p <= cfg_a[A_P2P]; // [RQ9]
         oc_master <= cfg_a[A_MASTER]; // [RQ10]
         one_step <= cfg_a[A_ONE_STEP]; // [RQ11]
      end
   end

   // classifier: the decision uses the fields as they stand at frm_start, so a
   // write finished before that edge applies and a later one waits for the next frame
   wire det_eth = (frm_encap == ENC_ETH) & cfg_a[A_DET_ETH]; // [RQ7]
   wire det_ip = ((frm_encap == ENC_V4) & cfg_a[A_DET_V4])
               | ((frm_encap == ENC_V6) & cfg_a[A_DET_V6]); // [RQ8]
   wire udp_ptp = (frm_udp_port == UDP_EVENT_PORT) | (frm_udp_port == UDP_GENERAL_PORT);
   wire uni_hit = cfg_b[B_UNICAST] & det_ip & udp_ptp & ~frm_reserved_addr
                & ~frm_mcast; // [RQ12] [RQ13]
   wire is_ptp = ptp_on & (((det_eth | det_ip) & frm_mcast) | uni_hit); // [RQ3]
   wire is_event = ~frm_msg_type[3];
   wire sync_like = (frm_msg_type == MSG_SYNC) | (frm_msg_type == MSG_DELAY_REQ);
   wire master_in = sync_like & frm_from_master & ~frm_on_host;
   wire fup_chk = (frm_msg_type == MSG_FOLLOW_UP) & cfg_b[B_ASSOC];

   logic next_host;
   logic next_others;
   always_comb begin
      next_host = ~frm_on_host;
      next_others = 1'b1;
      if (!is_ptp) begin
         next_host = 1'b0;
         next_others = 1'b0;
      end else if (bridge_on) begin
         // bridging claims every timing frame, unicast ones included
         next_host = 1'b1; // [RQ2]
         next_others = 1'b0;
      end else if (uni_hit) begin
         next_host = 1'b0; // [RQ12]
         next_others = 1'b0;
      end else if (master_in && frm_same_domain) begin
         next_host = 1'b0; // [RQ15]
         next_others = cfg_b[B_ALT_MASTER]; // [RQ14]
      end else if (master_in) begin
         next_host = 1'b0;
         next_others = 1'b1; // [RQ15]
      end else if (fup_chk) begin
         next_host = frm_assoc_ok & ~frm_on_host; // [RQ18]
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cls_valid <= 1'b0;
         cls_is_ptp <= 1'b0;
         cls_use_lookup <= 1'b0;
         cls_to_host <= 1'b0;
         cls_to_others <= 1'b0;
         cls_top_queue <= 1'b0;
         cls_hdr_edit <= 1'b0;
      end else begin
         cls_valid <= frm_start; // [RQ19]
         if (frm_start) begin
            cls_is_ptp <= is_ptp; // [RQ3]
            cls_use_lookup <= ~is_ptp | (uni_hit & ~bridge_on); // [RQ12]
            cls_to_host <= next_host;
            cls_to_others <= next_others;
            cls_top_queue <= is_ptp & (cfg_b[B_PRIO_ALL] | is_event); // [RQ16] [RQ17]
            cls_hdr_edit <= is_ptp & ~bridge_on; // [RQ2] [RQ4]
         end
      end
   end

   // helper copies of the fields seen at each frame start
   logic snap_bridge;
   logic snap_assoc;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         snap_bridge <= 1'b0;
         snap_assoc <= 1'b0;
      end else if (frm_start) begin
         snap_bridge <= bridge_on;
         snap_assoc <= cfg_b[B_ASSOC];
      end
   end

   sequence wr_taken_s;
      aw_got && w_got && !s_axi_bvalid;
   endsequence

   // the response code must match the decode of the address that was taken
   sequence resp_up_s;
      s_axi_bvalid && s_axi_bresp == ($past(wr_a | wr_b) ? RESP_OKAY : RESP_SLVERR);
   endsequence

   bridge_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode_bridge |-> $past(cfg_a[A_PTP_EN]))
      else $error("bridge mode active without timing mode enable"); // [RQ1]

   bridge_host_a: assert property (@(posedge clk) disable iff (sys_rst)
      cls_valid && cls_is_ptp && snap_bridge |-> cls_to_host && !cls_hdr_edit)
      else $error("bridge mode frame not sent unmodified to host"); // [RQ2]

   clk_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(cfg_a[A_PTP_EN]) |=> ptp_clk_en && tail_tag_ts)
      else $error("timing clock or tail tag not enabled"); // [RQ5]

   ptp_needs_en_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && !cfg_a[A_PTP_EN] |=> cls_valid && !cls_is_ptp && !cls_hdr_edit)
      else $error("frame classed as timing while mode off"); // [RQ3]

   eth_detect_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && frm_encap == ENC_ETH && !cfg_a[A_DET_ETH] |=> !cls_is_ptp)
      else $error("ethernet timing frame detected while disabled"); // [RQ7]

   ip_detect_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && ((frm_encap == ENC_V4 && !cfg_a[A_DET_V4])
      || (frm_encap == ENC_V6 && !cfg_a[A_DET_V6])) |=> !cls_is_ptp)
      else $error("ip timing frame detected while disabled"); // [RQ8]

   uni_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && !frm_mcast && !cfg_b[B_UNICAST] |=> !cls_is_ptp)
      else $error("unicast frame recognised with unicast off"); // [RQ13]

   prio_queue_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && cfg_b[B_PRIO_ALL] |=> cls_top_queue == cls_is_ptp)
      else $error("timing frame not in top queue"); // [RQ16]

   event_queue_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && !cfg_b[B_PRIO_ALL] && frm_msg_type[3] |=> !cls_top_queue)
      else $error("general message in top queue"); // [RQ17]

   assoc_fup_a: assert property (@(posedge clk) disable iff (sys_rst)
      cls_valid && snap_assoc && cls_is_ptp && !snap_bridge
      && $past(frm_msg_type) == MSG_FOLLOW_UP && !$past(frm_assoc_ok) |-> !cls_to_host)
      else $error("unmatched follow_up sent to host"); // [RQ18]

   alt_master_a: assert property (@(posedge clk) disable iff (sys_rst)
      frm_start && is_ptp && !bridge_on && !uni_hit && master_in && frm_same_domain
      |=> !cls_to_host && cls_to_others == $past(cfg_b[B_ALT_MASTER]))
      else $error("alternate master forwarding wrong"); // [RQ14] [RQ15]

   write_apply_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_taken_s |=> resp_up_s ##0 (cfg_a == $past(next_cfg_a)) ##0 (cfg_b == $past(next_cfg_b)))
      else $error("write not applied with its response"); // [RQ19]

   ro_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_a[15:8] == 8'h00 && cfg_b[15:13] == 3'h0 && cfg_b[8:0] == 9'h000)
      else $error("reserved bits not zero");

endmodule

// >>> ptpc_pkg.sv
// constants for the timing-message configuration bank: offsets, fields, resets
// assumes a 32-bit axi4-lite master with 16-bit byte addresses
// Notes on behaviour
// RQ1: bridging-mode bit only matters while the timing mode enable bit is set.
// RQ2: bridging mode sends every timing message to host, headers left untouched.
// RQ3: timing mode enabled identifies message type and gives special forwarding.
// RQ4: timing mode enabled allows header rewrite and timestamp insertion.
// RQ5: timing mode enable switches on the internal timing clock.
// RQ6: timing mode enabled selects timestamp-carrying tail tag layout on host port.
// RQ7: raw ethernet timing frames recognised only while its detect bit set; resets one.
// RQ8: ipv4/udp and ipv6/udp recognition each gated by own bit; both reset one.
// RQ9: transparent clock peer-to-peer when bit one, end-to-end when zero (reset).
// RQ10: host port master ordinary clock when bit one, slave when zero (default).
// RQ11: one-step clock when bit one (reset), two-step when zero.
// RQ12: unicast on: udp port 319/320 non-reserved address is unicast, table lookup.
// RQ13: unicast off: only multicast-addressed frames count as timing frames.
// RQ14: alternate master on: same-domain sync/delay_req from master go to non-host ports.
// RQ15: alternate master off: same-domain ones dropped at host, other domains to non-host.
// RQ16: priority bit set: all timing messages use highest transmit queue.
// RQ17: priority bit clear: only event messages use highest transmit queue.
// RQ18: association check on: follow_up goes to host only if matching sync pair.
// RQ19: configuration writes apply to frames starting after the write completes.
package ptpc_pkg;
   localparam int ADDR_W = 16;
   // printed offsets are not all word aligned, so they are indices
   localparam logic [ADDR_W-1:0] CFG_A_IDX = 16'h0514;
   localparam logic [ADDR_W-1:0] CFG_B_IDX = 16'h0516;
   localparam logic [ADDR_W-1:0] CFG_A_ADDR = 16'(CFG_A_IDX * 4);
   localparam logic [ADDR_W-1:0] CFG_B_ADDR = 16'(CFG_B_IDX * 4);
   localparam logic [15:0] CFG_A_RST = 16'h0039;
   localparam logic [15:0] CFG_B_RST = 16'h1000;
   localparam logic [15:0] CFG_A_WMASK = 16'h00ff;
   localparam logic [15:0] CFG_B_WMASK = 16'h1e00;
   // register a fields
   localparam int A_TAB = 7;
   localparam int A_PTP_EN = 6;
   localparam int A_DET_ETH = 5;
   localparam int A_DET_V4 = 4;
   localparam int A_DET_V6 = 3;
   localparam int A_P2P = 2;
   localparam int A_MASTER = 1;
   localparam int A_ONE_STEP = 0;
   // register b fields
   localparam int B_UNICAST = 12;
   localparam int B_ALT_MASTER = 11;
   localparam int B_PRIO_ALL = 10;
   localparam int B_ASSOC = 9;
   // frame encapsulation codes
   localparam logic [1:0] ENC_NONE = 2'h0;
   localparam logic [1:0] ENC_ETH = 2'h1;
   localparam logic [1:0] ENC_V4 = 2'h2;
   localparam logic [1:0] ENC_V6 = 2'h3;
   localparam logic [3:0] MSG_SYNC = 4'h0;
   localparam logic [3:0] MSG_DELAY_REQ = 4'h1;
   localparam logic [3:0] MSG_FOLLOW_UP = 4'h8;
   localparam logic [15:0] UDP_EVENT_PORT = 16'h013f;
   localparam logic [15:0] UDP_GENERAL_PORT = 16'h0140;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> ptpc_regs_tb.sv
// self-checking bench for the timing-message configuration bank
// assumes ptpc_pkg is compiled first; drives the axi4-lite slave and frame descriptors directly
`timescale 1ns/1ps
module ptpc_regs_tb;
   import ptpc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000, frm_udp_port = 16'h0000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0, frm_msg_type = 4'h0;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [1:0] frm_encap = 2'h0;
   logic frm_start = 1'b0, frm_mcast = 1'b0, frm_reserved_addr = 1'b0;
   logic frm_same_domain = 1'b0, frm_from_master = 1'b0, frm_on_host = 1'b0, frm_assoc_ok = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic cls_valid, cls_is_ptp, cls_use_lookup, cls_to_host, cls_to_others, cls_top_queue;
   logic cls_hdr_edit, ptp_clk_en, tail_tag_ts, mode_bridge, tc_p2p, oc_master, one_step;
   int num_errors = 0;
   int n_checks = 0;
   wire [5:0] cls = {cls_is_ptp, cls_use_lookup, cls_to_host, cls_to_others, cls_top_queue,
      cls_hdr_edit};
   wire [5:0] st = {mode_bridge, ptp_clk_en, tail_tag_ts, tc_p2p, oc_master, one_step};

   ptpc_regs dut_u (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .frm_start, .frm_encap, .frm_msg_type,
      .frm_mcast, .frm_reserved_addr, .frm_udp_port, .frm_same_domain, .frm_from_master,
      .frm_on_host, .frm_assoc_ok, .cls_valid, .cls_is_ptp, .cls_use_lookup, .cls_to_host,
      .cls_to_others, .cls_top_queue, .cls_hdr_edit, .ptp_clk_en, .tail_tag_ts, .mode_bridge,
      .tc_p2p, .oc_master, .one_step);

   always #2 clk = ~clk;

   task end_of_test;
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // a wait that ran out of its bound ends the run
   task tmo(input int n);
      if (n >= 100) begin
         num_errors++;
         end_of_test;
      end
   endtask

   task chk_st(input logic [5:0] e);
      #1;
      chk("status", {26'h0, e}, {26'h0, st});
   endtask

   task axi_wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw, w;
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_bready <= 1'b1;
      while ((aw || w) && n < 100) begin
         @(posedge clk);
         n++;
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge clk);
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      tmo(n);
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask

   task axi_rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 100);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      tmo(n);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask

   // fl packs same domain, from master, on host, association match
   task frm(input logic [1:0] en, input logic [3:0] ty, input logic mc, input logic [15:0] pt,
      input logic [3:0] fl, input logic [5:0] e, input logic [5:0] m = 6'h3f);
      @(posedge clk);
      frm_start <= 1'b1;
      frm_encap <= en;
      frm_msg_type <= ty;
      frm_mcast <= mc;
      frm_udp_port <= pt;
      {frm_same_domain, frm_from_master, frm_on_host, frm_assoc_ok} <= fl;
      @(posedge clk);
      frm_start <= 1'b0;
      #1;
      chk("cls_valid", 32'h1, {31'h0, cls_valid});
      chk("cls", {26'h0, e & m}, {26'h0, cls & m});
      @(posedge clk);
      #1;
      chk("cls_valid", 32'h0, {31'h0, cls_valid});
   endtask

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      chk_st(6'h01);
      axi_rd(CFG_A_ADDR, 32'h0000_0039, RESP_OKAY);
      axi_rd(CFG_B_ADDR, 32'h0000_1000, RESP_OKAY);
      frm(ENC_ETH, MSG_SYNC, 1'b1, 16'h0000, 4'h0, 6'h10);
      axi_wr(CFG_A_ADDR, 32'hffff_ffff, RESP_OKAY);
      chk_st(6'h3f);
      axi_rd(CFG_A_ADDR, 32'h0000_00ff, RESP_OKAY);
      axi_wr(CFG_A_ADDR, 32'h0000_0080, RESP_OKAY);
      chk_st(6'h00);
      axi_wr(CFG_A_ADDR, 32'h0000_0046, RESP_OKAY);
      chk_st(6'h1e);
      axi_wr(CFG_B_ADDR, 32'h0000_ffff, RESP_OKAY);
      axi_rd(CFG_B_ADDR, 32'h0000_1e00, RESP_OKAY);
      // unmapped word between the two registers
      axi_wr(16'h1454, 32'h0000_ffff, RESP_SLVERR);
      axi_rd(16'h1454, 32'h0000_0000, RESP_SLVERR);
      axi_wr(CFG_A_ADDR, 32'h0000_0040, RESP_OKAY);
      axi_wr(CFG_B_ADDR, 32'h0000_0000, RESP_OKAY);
      frm(ENC_ETH, MSG_SYNC, 1'b1, 16'h0000, 4'h0, 6'h10);
      frm(ENC_V4, MSG_SYNC, 1'b1, 16'h0000, 4'h0, 6'h10);
      axi_wr(CFG_A_ADDR, 32'h0000_0078, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         frm(2'(i), MSG_SYNC, 1'b1, 16'h0000, 4'h0, (i == 0) ? 6'h10 : 6'h2f);
      end
      frm(ENC_ETH, MSG_FOLLOW_UP, 1'b1, 16'h0000, 4'h0, 6'h2d);
      frm(ENC_ETH, MSG_SYNC, 1'b1, 16'h0000, 4'hc, 6'h23);
      frm(ENC_ETH, MSG_DELAY_REQ, 1'b1, 16'h0000, 4'h4, 6'h27);
      frm(ENC_V4, MSG_SYNC, 1'b0, UDP_EVENT_PORT, 4'h0, 6'h10);
      axi_wr(CFG_B_ADDR, 32'h0000_1000, RESP_OKAY);
      frm(ENC_V4, MSG_SYNC, 1'b0, UDP_EVENT_PORT, 4'h0, 6'h33);
      frm(ENC_V6, MSG_FOLLOW_UP, 1'b0, UDP_GENERAL_PORT, 4'h0, 6'h31);
      frm(ENC_V4, MSG_SYNC, 1'b0, 16'h0141, 4'h0, 6'h10);
      @(posedge clk);
      frm_reserved_addr <= 1'b1;
      frm(ENC_V4, MSG_SYNC, 1'b0, UDP_EVENT_PORT, 4'h0, 6'h10);
      @(posedge clk);
      frm_reserved_addr <= 1'b0;
      axi_wr(CFG_B_ADDR, 32'h0000_0c00, RESP_OKAY);
      frm(ENC_ETH, MSG_DELAY_REQ, 1'b1, 16'h0000, 4'hc, 6'h27);
      frm(ENC_ETH, MSG_FOLLOW_UP, 1'b1, 16'h0000, 4'h0, 6'h2f);
      axi_wr(CFG_B_ADDR, 32'h0000_0200, RESP_OKAY);
      frm(ENC_ETH, MSG_FOLLOW_UP, 1'b1, 16'h0000, 4'h0, 6'h00, 6'h08);
      frm(ENC_ETH, MSG_FOLLOW_UP, 1'b1, 16'h0000, 4'h1, 6'h08, 6'h08);
      frm(ENC_ETH, MSG_FOLLOW_UP, 1'b1, 16'h0000, 4'h3, 6'h00, 6'h08);
      axi_wr(CFG_A_ADDR, 32'h0000_00f8, RESP_OKAY);
      chk_st(6'h38);
      frm(ENC_ETH, MSG_SYNC, 1'b1, 16'h0000, 4'h0, 6'h2a);
      axi_wr(CFG_B_ADDR, 32'h0000_1000, RESP_OKAY);
      frm(ENC_V4, MSG_SYNC, 1'b0, UDP_EVENT_PORT, 4'h0, 6'h2a);
      end_of_test;
   end
endmodule
